// ===== rtl/cvt_pkg.sv
// constants, state and fault encodings for the constant velocity task block
// Functional notes
// - task starts only on start rising edge
// - zero set velocity passes the range check
// - direction code: 0 sign, 1 positive, 2 negative
// - maintain mode keeps present axis speed
// - maintain mode: reached once speed held
// - normal mode: reached at set velocity, hold
// - busy true while task executes
// - takeover by another task flags aborted
// - execution failure sets error and fault words
// - listed task kinds may abort this task
// - own start aborts any active listed task
// - abort before target still flags aborted
// - zero velocity decelerates axis like halt
// - zero stop: reached high one cycle minimum
// - busy falls together with velocity reached
// - start held high latches reached and busy
// - accepted start sets speed mode flag
// - zero task standstill sets steady speed flag
// - any new task updates both axis flags
package cvt_pkg;
    localparam int CVT_VEL_W = 16;
    localparam int CVT_WORD_W = 16;
    localparam logic [15:0] CVT_DIR_SIGN = 16'h0000;
    localparam logic [15:0] CVT_DIR_POS = 16'h0001;
    localparam logic [15:0] CVT_DIR_NEG = 16'h0002;
    localparam logic [15:0] CVT_FAULT_NONE = 16'h0000;
    localparam logic [15:0] CVT_FAULT_VEL_RANGE = 16'h8001;
    localparam logic [15:0] CVT_FAULT_DIR_CODE = 16'h8002;
    localparam logic [15:0] CVT_FAULT_AXIS_OFF = 16'h8003;
    localparam logic [15:0] CVT_FAULT_AXIS_LOST = 16'h8004;
    typedef enum logic [1:0] {CVT_IDLE, CVT_RAMP, CVT_RUN, CVT_STOPPED} cvt_state_t;
endpackage : cvt_pkg

// ===== rtl/cvt_ramp.sv
// speed ramp generator: steps the axis speed toward a signed target
module cvt_ramp #(
    parameter int VEL_W = cvt_pkg::CVT_VEL_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic signed [VEL_W-1:0] target,
    input wire logic [VEL_W-1:0] accel_step,
    input wire logic [VEL_W-1:0] decel_step,
    output logic signed [VEL_W-1:0] speed,
    output logic at_target
);
    import cvt_pkg::*;

    typedef struct packed {
        logic signed [VEL_W-1:0] speed;
    } cvt_ramp_st_t;

    cvt_ramp_st_t st_ff;
    cvt_ramp_st_t nxt_st;
    logic signed [VEL_W:0] diff;
    logic [VEL_W:0] abs_diff;
    logic [VEL_W:0] step;
    logic [VEL_W:0] chosen;
    logic signed [VEL_W:0] sum;
    logic speeding_up;

    always_comb
    begin
        nxt_st = st_ff;
        diff = {target[VEL_W-1], target} - {st_ff.speed[VEL_W-1], st_ff.speed};
        abs_diff = diff[VEL_W] ? (~diff + 1'b1) : diff;
        // moving away from zero uses acceleration, toward zero uses deceleration
        speeding_up = (st_ff.speed == '0) || (diff[VEL_W] == st_ff.speed[VEL_W-1]);
        step = speeding_up ? {1'b0, accel_step} : {1'b0, decel_step};
        chosen = (abs_diff < step) ? abs_diff : step;
        sum = diff[VEL_W] ? ({st_ff.speed[VEL_W-1], st_ff.speed} - $signed(chosen))
                          : ({st_ff.speed[VEL_W-1], st_ff.speed} + $signed(chosen));
        nxt_st.speed = sum[VEL_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign speed = st_ff.speed;
    assign at_target = (st_ff.speed == target);

    chk_no_overshoot: assert property (@(posedge clk) disable iff (!resetn)
        at_target |=> $stable(speed))
        else $error("ramp left a steady target");
endmodule : cvt_ramp

// ===== rtl/cvt_task.sv
// constant velocity task controller with abort, fault and axis flag handling
module cvt_task #(
    parameter int VEL_W = cvt_pkg::CVT_VEL_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic execute,
    input wire logic signed [VEL_W-1:0] velocity,
    input wire logic [cvt_pkg::CVT_WORD_W-1:0] direction,
    input wire logic maintain_current,
    input wire logic axis_enabled,
    input wire logic [VEL_W-1:0] start_stop_vel,
    input wire logic [VEL_W-1:0] max_vel,
    input wire logic [VEL_W-1:0] accel_step,
    input wire logic [VEL_W-1:0] decel_step,
    input wire logic other_task_start,
    input wire logic other_speed_mode,
    input wire logic other_steady_speed,
    output logic velocity_reached,
    output logic busy,
    output logic task_aborted,
    output logic error,
    output logic [cvt_pkg::CVT_WORD_W-1:0] fault_code,
    output logic [cvt_pkg::CVT_WORD_W-1:0] fault_detail,
    output logic abort_others,
    output logic speed_mode_flag,
    output logic steady_speed_flag,
    output logic signed [VEL_W-1:0] axis_speed
);
    import cvt_pkg::*;

    typedef struct packed {
        cvt_state_t state;
        logic exec_prev;
        logic signed [VEL_W-1:0] target;
        logic reached;
        logic busy;
        logic aborted;
        logic error;
        logic [CVT_WORD_W-1:0] fault_code;
        logic [CVT_WORD_W-1:0] fault_detail;
        logic abort_others;
        logic speed_mode;
        logic steady;
    } cvt_task_st_t;

    cvt_task_st_t st_ff;
    cvt_task_st_t nxt_st;
    logic start_pulse;
    logic [VEL_W:0] vel_mag;
    logic mag_ok;
    logic dir_ok;
    logic accepted;
    logic rejected;
    logic [CVT_WORD_W-1:0] reject_code;
    logic [CVT_WORD_W-1:0] reject_detail;
    logic signed [VEL_W-1:0] new_target;
    logic signed [VEL_W:0] neg_mag;
    logic at_target;

    cvt_ramp #(
        .VEL_W(VEL_W)
    ) u_ramp (
        .clk(clk),
        .resetn(resetn),
        .target(st_ff.target),
        .accel_step(accel_step),
        .decel_step(decel_step),
        .speed(axis_speed),
        .at_target(at_target)
    );

    // start qualification, combinational off the inputs, the stored execute level and the axis speed
    always_comb
    begin
        start_pulse = execute && !st_ff.exec_prev;
        vel_mag = velocity[VEL_W-1] ? (~{1'b1, velocity} + 1'b1) : {1'b0, velocity};
        // range limits are the caller's to respect; out of range is caught anyway
        mag_ok = (vel_mag == '0)
            || ((vel_mag >= {1'b0, start_stop_vel}) && (vel_mag <= {1'b0, max_vel}));
        dir_ok = (direction == CVT_DIR_SIGN) || (direction == CVT_DIR_POS) || (direction == CVT_DIR_NEG);
        reject_code = CVT_FAULT_NONE;
        reject_detail = CVT_FAULT_NONE;
        if (!axis_enabled)
        begin
            reject_code = CVT_FAULT_AXIS_OFF;
        end
        else if (!maintain_current && !dir_ok)
        begin
            reject_code = CVT_FAULT_DIR_CODE;
            reject_detail = direction;
        end
        else if (!maintain_current && !mag_ok)
        begin
            reject_code = CVT_FAULT_VEL_RANGE;
            reject_detail = CVT_WORD_W'(vel_mag);
        end
        rejected = start_pulse && (reject_code != CVT_FAULT_NONE);
        accepted = start_pulse && (reject_code == CVT_FAULT_NONE);
        neg_mag = ~vel_mag + 1'b1;
        case (direction)
            CVT_DIR_POS: new_target = vel_mag[VEL_W-1:0];
            CVT_DIR_NEG: new_target = neg_mag[VEL_W-1:0];
            default: new_target = velocity;
        endcase
        if (maintain_current)
            new_target = axis_speed;
    end

    // own start outranks a simultaneous takeover: the newer request is ours
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.exec_prev = execute;
        nxt_st.abort_others = 1'b0;
        if (accepted)
        begin
            nxt_st.abort_others = 1'b1;
            nxt_st.target = new_target;
            nxt_st.state = CVT_RAMP;
            nxt_st.busy = 1'b1;
            nxt_st.reached = 1'b0;
            nxt_st.aborted = 1'b0;
            nxt_st.error = 1'b0;
            nxt_st.fault_code = CVT_FAULT_NONE;
            nxt_st.fault_detail = CVT_FAULT_NONE;
            nxt_st.speed_mode = 1'b1;
            nxt_st.steady = 1'b0;
        end
        else if (rejected)
        begin
            nxt_st.state = CVT_IDLE;
            nxt_st.busy = 1'b0;
            nxt_st.reached = 1'b0;
            nxt_st.aborted = 1'b0;
            nxt_st.error = 1'b1;
            nxt_st.fault_code = reject_code;
            nxt_st.fault_detail = reject_detail;
        end
        else if (other_task_start)
        begin
            // homing mode 3, halt, both moves, another velocity task or jog
            if (st_ff.busy)
            begin
                nxt_st.aborted = 1'b1;
                nxt_st.busy = 1'b0;
                nxt_st.reached = 1'b0;
                nxt_st.state = CVT_IDLE;
            end
            nxt_st.speed_mode = other_speed_mode;
            nxt_st.steady = other_steady_speed;
        end
        else if (st_ff.busy && !axis_enabled)
        begin
            nxt_st.error = 1'b1;
            nxt_st.fault_code = CVT_FAULT_AXIS_LOST;
            nxt_st.fault_detail = CVT_WORD_W'(axis_speed);
            nxt_st.busy = 1'b0;
            nxt_st.reached = 1'b0;
            nxt_st.target = '0;
            nxt_st.state = CVT_IDLE;
        end
        else
        begin
            case (st_ff.state)
                CVT_RAMP:
                begin
                    if (at_target)
                    begin
                        nxt_st.reached = 1'b1;
                        if (st_ff.target == '0)
                        begin
                            nxt_st.steady = 1'b1;
                            nxt_st.state = CVT_STOPPED;
                        end
                        else
                        begin
                            nxt_st.state = CVT_RUN;
                        end
                    end
                end
                CVT_RUN:
                begin
                    nxt_st.reached = at_target;
                end
                CVT_STOPPED:
                begin
                    // held start keeps both outputs latched
                    if (!execute)
                    begin
                        nxt_st.reached = 1'b0;
                        nxt_st.busy = 1'b0;
                        nxt_st.state = CVT_IDLE;
                    end
                end
                default:
                begin
                    nxt_st.state = CVT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_ff <= '0;
            st_ff.state <= CVT_IDLE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign velocity_reached = st_ff.reached;
    assign busy = st_ff.busy;
    assign task_aborted = st_ff.aborted;
    assign error = st_ff.error;
    assign fault_code = st_ff.fault_code;
    assign fault_detail = st_ff.fault_detail;
    assign abort_others = st_ff.abort_others;
    assign speed_mode_flag = st_ff.speed_mode;
    assign steady_speed_flag = st_ff.steady;

    default clocking cvt_cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_good_start;
        accepted && !maintain_current;
    endsequence

    sequence s_zero_reach;
        $rose(st_ff.reached) && (st_ff.target == '0);
    endsequence

    sequence s_zero_run;
        (st_ff.state == CVT_RAMP) && (st_ff.target == '0) && (decel_step != '0);
    endsequence

    chk_start_on_edge: assert property ($rose(st_ff.busy) |-> $past(start_pulse))
        else $error("busy rose without a start edge");

    chk_zero_accepted: assert property (start_pulse && axis_enabled && !maintain_current && dir_ok
        && (velocity == '0) |=> st_ff.busy && !st_ff.error)
        else $error("zero velocity start was refused");

    chk_dir_positive: assert property (s_good_start and (direction == CVT_DIR_POS) && (vel_mag != '0)
        |=> st_ff.target > 0)
        else $error("positive direction did not give positive target");

    chk_dir_negative: assert property (s_good_start and (direction == CVT_DIR_NEG) && (vel_mag != '0)
        |=> st_ff.target < 0)
        else $error("negative direction did not give negative target");

    chk_maintain_speed: assert property (accepted && maintain_current
        |=> (st_ff.target == $past(axis_speed)) ##1 st_ff.reached)
        else $error("maintain mode did not hold present speed");

    chk_reached_match: assert property ($rose(st_ff.reached) |-> (axis_speed == st_ff.target) && st_ff.busy)
        else $error("reached raised away from target");

    chk_takeover_abort: assert property (st_ff.busy && other_task_start && !start_pulse
        |=> st_ff.aborted && !st_ff.busy && !st_ff.reached)
        else $error("takeover not flagged as aborted");

    chk_lost_axis: assert property (st_ff.busy && !axis_enabled && !start_pulse && !other_task_start
        |=> st_ff.error && (st_ff.fault_code == CVT_FAULT_AXIS_LOST))
        else $error("axis loss gave no fault");

    chk_abort_others: assert property (accepted |=> abort_others ##1 !abort_others)
        else $error("start did not pulse abort of other tasks");

    chk_zero_flags: assert property (s_zero_reach |-> st_ff.busy && st_ff.steady && (axis_speed == '0))
        else $error("zero stop without steady flag");

    chk_busy_with_reach: assert property ($fell(st_ff.reached) && (st_ff.state == CVT_IDLE)
        && !$past(other_task_start) && !$past(start_pulse) && $past(axis_enabled) |-> $fell(st_ff.busy))
        else $error("busy and reached did not fall together");

    chk_latch_held: assert property ((st_ff.state == CVT_STOPPED) && execute && axis_enabled
        && !other_task_start && !start_pulse |=> st_ff.reached && st_ff.busy)
        else $error("held start did not latch outputs");

    chk_range_reject: assert property (start_pulse && axis_enabled && !maintain_current && dir_ok && !mag_ok
        |=> st_ff.error && (st_ff.fault_code == CVT_FAULT_VEL_RANGE) && !st_ff.busy)
        else $error("out of range velocity accepted");

    chk_speed_mode: assert property (accepted |=> st_ff.speed_mode && !st_ff.steady)
        else $error("speed mode flag not set on start");

    chk_dir_reject: assert property (start_pulse && axis_enabled && !maintain_current && !dir_ok
        |=> st_ff.error && (st_ff.fault_code == CVT_FAULT_DIR_CODE) && (st_ff.fault_detail == $past(direction)))
        else $error("bad direction code accepted");

    chk_off_reject: assert property (start_pulse && !axis_enabled
        |=> st_ff.error && (st_ff.fault_code == CVT_FAULT_AXIS_OFF) && !st_ff.busy)
        else $error("start on disabled axis accepted");

    chk_start_clears: assert property (accepted
        |=> !st_ff.error && !st_ff.aborted && (st_ff.fault_code == CVT_FAULT_NONE) && (st_ff.fault_detail == '0))
        else $error("accepted start left stale status");

    chk_held_no_start: assert property (execute && $past(execute)
        |=> !abort_others)
        else $error("held start input started a task");

    chk_error_not_busy: assert property (st_ff.error |-> !st_ff.busy)
        else $error("busy while error stands");

    chk_aborted_idle: assert property (st_ff.aborted |-> !st_ff.busy)
        else $error("busy while aborted stands");

    chk_reached_busy: assert property (st_ff.reached |-> st_ff.busy)
        else $error("reached without busy");

    chk_zero_decel_pos: assert property (s_zero_run ##0 (axis_speed > 0)
        |=> axis_speed < $past(axis_speed))
        else $error("zero task did not slow a forward axis");

    chk_zero_decel_neg: assert property (s_zero_run ##0 (axis_speed < 0)
        |=> axis_speed > $past(axis_speed))
        else $error("zero task did not slow a reverse axis");

    chk_run_steady: assert property ((st_ff.state == CVT_RUN) && !start_pulse && !other_task_start
        && axis_enabled |=> st_ff.busy && $stable(st_ff.target))
        else $error("running task lost its target");

    chk_flags_follow: assert property (other_task_start && !start_pulse
        |=> (st_ff.speed_mode == $past(other_speed_mode)) && (st_ff.steady == $past(other_steady_speed)))
        else $error("axis flags did not follow the new task");

    chk_abort_sticky: assert property (st_ff.aborted && !start_pulse |=> st_ff.aborted)
        else $error("aborted dropped without a new start");

    chk_zero_stop_state: assert property (s_zero_reach |-> (st_ff.state == CVT_STOPPED))
        else $error("zero task reached without standstill state");

    chk_maintain_accept: assert property (start_pulse && axis_enabled && maintain_current
        |=> st_ff.busy && !st_ff.error)
        else $error("maintain start was refused");
endmodule : cvt_task

// ===== verification/cvt_other_task.sv
// model of the neighbouring motion tasks that may take over the axis
module cvt_other_task (
    input wire logic clk,
    input wire logic fire,
    input wire logic [2:0] kind,
    output logic other_task_start,
    output logic other_speed_mode,
    output logic other_steady_speed
);
    timeunit 1ns;
    timeprecision 1ps;
    // kinds: 0 homing mode 3, 1 halt, 2 absolute, 3 relative, 4 velocity, 5 jog
    initial
    begin
        other_task_start = 1'b0;
        other_speed_mode = 1'b0;
        other_steady_speed = 1'b0;
    end
    always @(posedge clk)
    begin
        other_task_start <= fire;
        if (fire)
        begin
            other_speed_mode <= (kind == 3'h4) || (kind == 3'h5);
            other_steady_speed <= (kind == 3'h1);
        end
        else
        begin
            // flags only count with the start pulse, so they toggle meanwhile
            other_speed_mode <= ~other_speed_mode;
            other_steady_speed <= ~other_steady_speed;
        end
    end
endmodule : cvt_other_task

// ===== verification/tb.sv
// self-checking bench for the constant velocity task controller
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cvt_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic execute = 1'b0;
    logic signed [15:0] velocity = 16'sh0000;
    logic [15:0] direction = 16'h0000;
    logic maintain_current = 1'b0;
    logic axis_enabled = 1'b1;
    logic fire = 1'b0;
    logic [2:0] kind = 3'h0;
    logic other_task_start, other_speed_mode, other_steady_speed, velocity_reached, busy;
    logic task_aborted, error, abort_others, speed_mode_flag, steady_speed_flag;
    logic [15:0] fault_code, fault_detail;
    logic signed [15:0] axis_speed, v, exp_v;
    logic [31:0] seed = 32'h0890;
    logic signed [15:0] bad_v [4] = '{16'sd50, -16'sd1200, 16'sd200, 16'sd200};
    logic [15:0] bad_d [4] = '{16'h0000, 16'h0000, 16'h0003, 16'h0000};
    logic [15:0] bad_c [4] = '{16'h8001, 16'h8001, 16'h8002, 16'h8003};
    logic [15:0] bad_i [4] = '{16'h0032, 16'h04b0, 16'h0003, 16'h0000};
    int fails = 0;
    int checks = 0;
    int cycles = 0;

    cvt_task i_dut (.clk, .resetn, .execute, .velocity, .direction, .maintain_current, .axis_enabled,
        .start_stop_vel(16'h0064), .max_vel(16'h03e8), .accel_step(16'h0032), .decel_step(16'h0032),
        .other_task_start, .other_speed_mode, .other_steady_speed, .velocity_reached, .busy,
        .task_aborted, .error, .fault_code, .fault_detail, .abort_others, .speed_mode_flag,
        .steady_speed_flag, .axis_speed);
    cvt_other_task i_other (.clk, .fire, .kind, .other_task_start, .other_speed_mode, .other_steady_speed);

    always #20 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic signed [15:0] exp_speed(logic signed [15:0] vel, logic [15:0] dir);
        logic signed [15:0] mag;
        mag = (vel < 0) ? -vel : vel;
        if (dir == CVT_DIR_POS) return mag;
        if (dir == CVT_DIR_NEG) return -mag;
        return vel;
    endfunction : exp_speed

    task automatic cmp_bit(string name, logic exp, logic got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s exp %b got %b", name, exp, got);
        end
    endtask : cmp_bit

    task automatic cmp_word(string name, logic [15:0] exp, logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask : cmp_word

    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    // execute stays high afterwards; the caller drops it
    task automatic start(logic signed [15:0] vel, logic [15:0] dir, logic keep);
        @(posedge clk);
        execute <= 1'b1;
        velocity <= vel;
        direction <= dir;
        maintain_current <= keep;
        @(posedge clk);
        #1;
    endtask : start

    task automatic drop_exec();
        @(posedge clk);
        execute <= 1'b0;
    endtask : drop_exec

    task automatic wait_reached();
        int n;
        n = 0;
        while (velocity_reached !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_reached

    task automatic other(logic [2:0] k);
        @(posedge clk);
        fire <= 1'b1;
        kind <= k;
        @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
        #1;
    endtask : other

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        cmp_bit("busy", 1'b0, busy);
        cmp_word("fault_code", CVT_FAULT_NONE, fault_code);
        cmp_word("fault_detail", 16'h0000, fault_detail);
        for (int i = 0; i < 9; i++)
        begin
            v = 16'(100 + rnd() % 901);
            if (rnd() & 1) v = -v;
            exp_v = exp_speed(v, 16'(i % 3));
            start(v, 16'(i % 3), 1'b0);
            cmp_bit("busy", 1'b1, busy);
            cmp_bit("abort_others", 1'b1, abort_others);
            cmp_bit("speed_mode", 1'b1, speed_mode_flag);
            cmp_bit("steady", 1'b0, steady_speed_flag);
            drop_exec();
            wait_reached();
            cmp_bit("reached", 1'b1, velocity_reached);
            cmp_word("axis_speed", exp_v, axis_speed);
        end
        // maintain mode ignores a bad direction and a zero velocity
        start(16'sh0000, 16'h0007, 1'b1);
        drop_exec();
        #1;
        cmp_bit("reached", 1'b1, velocity_reached);
        cmp_bit("error", 1'b0, error);
        repeat (3) @(posedge clk);
        #1;
        cmp_word("axis_speed", exp_v, axis_speed);
        for (int k = 0; k < 6; k++)
        begin
            start((k % 2) ? -16'sd900 : 16'sd900, 16'h0000, 1'b0);
            drop_exec();
            if (k % 2 == 0) wait_reached();
            else
            begin
                #1;
                cmp_bit("reached", 1'b0, velocity_reached);
            end
            other(3'(k));
            cmp_bit("aborted", 1'b1, task_aborted);
            cmp_bit("busy", 1'b0, busy);
            cmp_bit("speed_mode", (k == 4) || (k == 5), speed_mode_flag);
            cmp_bit("steady", k == 1, steady_speed_flag);
        end
        // zero set velocity: execute held high latches the outputs
        start(16'sh0000, 16'h0000, 1'b0);
        cmp_bit("error", 1'b0, error);
        cmp_bit("busy", 1'b1, busy);
        wait_reached();
        cmp_bit("reached", 1'b1, velocity_reached);
        cmp_word("axis_speed", 16'h0000, axis_speed);
        cmp_bit("steady", 1'b1, steady_speed_flag);
        repeat (5) @(posedge clk);
        #1;
        cmp_bit("reached", 1'b1, velocity_reached);
        cmp_bit("busy", 1'b1, busy);
        cmp_bit("abort_others", 1'b0, abort_others);
        drop_exec();
        @(posedge clk);
        #1;
        cmp_bit("reached", 1'b0, velocity_reached);
        cmp_bit("busy", 1'b0, busy);
        // axis enable is dropped for the last case only, set once per edge
        for (int i = 0; i < 4; i++)
        begin
            start(bad_v[i], bad_d[i], 1'b0);
            cmp_bit("error", 1'b1, error);
            cmp_bit("busy", 1'b0, busy);
            cmp_word("fault_code", bad_c[i], fault_code);
            cmp_word("fault_detail", bad_i[i], fault_detail);
            drop_exec();
            axis_enabled <= (i != 2);
        end
        // losing the axis enable in mid-run is a fault
        start(16'sd500, CVT_DIR_POS, 1'b0);
        cmp_bit("error", 1'b0, error);
        drop_exec();
        axis_enabled <= 1'b0;
        @(posedge clk);
        #1;
        cmp_bit("error", 1'b1, error);
        cmp_word("fault_code", CVT_FAULT_AXIS_LOST, fault_code);
        cmp_bit("busy", 1'b0, busy);
        give_verdict();
    end
endmodule : tb
